/* dpllms_pkg.sv */
// shared constants and types for the reference mode select block
package dpllms_pkg;
  // ==========================================================
  // register map (byte addresses on the APB)
  localparam logic [7:0] ADDR_MODE_ONE = 8'h00;
  localparam logic [7:0] ADDR_MODE_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [15:0] MODE_ONE_RESET = 16'h0000;
  localparam logic [15:0] MODE_TWO_RESET = 16'h0000;
  localparam logic [15:0] MODE_ONE_MASK = 16'h7fff;
  localparam logic [15:0] MODE_TWO_MASK = 16'h0720;
  // ==========================================================
  // field positions in pll_operation_mode_one
  localparam int M1_BDRV = 14;
  localparam int M1_ADRV = 13;
  localparam int M1_PREF = 12;
  localparam int M1_SFREQ_LO = 10;
  localparam int M1_PFREQ_LO = 8;
  localparam int M1_SSRC_LO = 4;
  localparam int M1_PSRC_LO = 0;
  // field positions in pll_operation_mode_two
  localparam int M2_IERR = 10;
  localparam int M2_FDM_LO = 8;
  localparam int M2_INV = 5;
  // status register fields
  localparam int ST_ROLE_LO = 0;
  localparam int ST_EXTFD = 2;
  localparam int ST_PRIBP = 3;
  localparam int ST_SECBP = 4;
  localparam int ST_BUSY = 5;
  // ==========================================================
  // field encodings
  localparam logic [1:0] FREQ_8K = 2'h0;
  localparam logic [1:0] FREQ_1544K = 2'h1;
  localparam logic [1:0] FREQ_2048K = 2'h2;
  localparam logic [1:0] FREQ_BPCLK = 2'h3;
  localparam logic [1:0] FDM_AUTO = 2'h0;
  localparam logic [1:0] FDM_EXT = 2'h1;
  localparam logic [3:0] SRC_BP_ONE = 4'h0;
  localparam logic [3:0] SRC_BP_TWO = 4'h1;
  localparam int SRC_LOCAL_BIT = 3;
  // operating role, from {b drive, a drive}
  typedef enum logic [1:0] {
    ROLE_SLAVE = 2'b00,
    ROLE_PRIMARY = 2'b01,
    ROLE_BOTH = 2'b11,
    ROLE_SECONDARY = 2'b10
  } dpllms_role_type;
  // ==========================================================
  // configuration word carried into the link domain
  localparam int CFG_W = 14;
  localparam int CFG_PSRC_LO = 0;
  localparam int CFG_PFREQ_LO = 4;
  localparam int CFG_SSRC_LO = 6;
  localparam int CFG_SFREQ_LO = 10;
  localparam int CFG_INV = 12;
  localparam int CFG_ACTSEC = 13;
  // synchronised link input vector
  localparam int LNK_W = 14;
  localparam int LNK_BP1 = 0;
  localparam int LNK_BP2 = 1;
  localparam int LNK_LOCAL_LO = 2;
  localparam int LNK_ACLK = 10;
  localparam int LNK_BCLK = 11;
  localparam int LNK_FRA = 12;
  localparam int LNK_FRB = 13;
endpackage

/* dpllms_cfg_sync.sv */
// toggle handshake carrying a configuration word across clock domains
`timescale 1ns/1ns
module dpllms_cfg_sync #(
  parameter int W = 14
) (
  // source side
  input wire logic src_clk,
  input wire logic rst_n,
  input wire logic src_ce,
  input wire logic [W-1:0] src_data,
  output logic busy,
  // destination side
  input wire logic dst_clk,
  output logic [W-1:0] dst_data
);
  typedef struct packed {
    logic [W-1:0] data;
    logic req;
    logic ack_s1;
    logic ack_s2;
  } dpllms_src_type;
  typedef struct packed {
    logic [W-1:0] data;
    logic req_s1;
    logic req_s2;
    logic req_s3;
  } dpllms_dst_type;
  dpllms_src_type s_q, s_d;
  dpllms_dst_type t_q, t_d;
  // ==========================================================
  // source domain: launch a new word only when the last one landed
  always_comb begin
    s_d = s_q;
    if (src_ce) begin
      s_d.ack_s1 = t_q.req_s3;
      s_d.ack_s2 = s_q.ack_s1;
      if (s_q.req == s_q.ack_s2 && src_data != s_q.data) begin
        s_d.data = src_data;
        s_d.req = ~s_q.req;
      end
    end
  end
  always_ff @(posedge src_clk or negedge rst_n) begin
    if (!rst_n) s_q <= '0;
    else s_q <= s_d;
  end
  // ==========================================================
  // destination domain: word is stable while the toggle travels
  always_comb begin
    t_d = t_q;
    t_d.req_s1 = s_q.req;
    t_d.req_s2 = t_q.req_s1;
    t_d.req_s3 = t_q.req_s2;
    if (t_q.req_s2 != t_q.req_s3) t_d.data = s_q.data;
  end
  always_ff @(posedge dst_clk or negedge rst_n) begin
    if (!rst_n) t_q <= '0;
    else t_q <= t_d;
  end
  assign busy = s_q.req ^ s_q.ack_s2;
  assign dst_data = t_q.data;
endmodule // dpllms_cfg_sync

/* dpllms_ref_mux.sv */
// registered reference source selector in the link domain
`timescale 1ns/1ns
module dpllms_ref_mux (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selection
  input wire logic [3:0] sel,
  input wire logic use_bp_clk,
  input wire logic invert,
  // synchronised sources
  input wire logic bp_clock,
  input wire logic bp_one,
  input wire logic bp_two,
  input wire logic [7:0] local_ref,
  // selected reference
  output logic ref_out
);
  typedef struct packed {
    logic ref_sel;
  } dpllms_mux_type;
  dpllms_mux_type q, d;
  always_comb begin
    d = q;
    if (use_bp_clk) d.ref_sel = bp_clock;
    else if (sel[dpllms_pkg::SRC_LOCAL_BIT])
      d.ref_sel = local_ref[sel[2:0]];
    else if (sel == dpllms_pkg::SRC_BP_ONE)
      d.ref_sel = bp_one ^ invert;
    else if (sel == dpllms_pkg::SRC_BP_TWO)
      d.ref_sel = bp_two ^ invert;
    else d.ref_sel = 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) q <= '0;
    else q <= d;
  end
  assign ref_out = q.ref_sel;
endmodule // dpllms_ref_mux

/* dpllms_top.sv */
// reference mode select: mode registers on APB and link-side selection
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Function
// - primary master role drives the A clock group, monitors the B group
// - secondary master role drives the B clock group, monitors the A group
// - slave role drives neither clock group and monitors both
// - preferred-reference bit zero makes the primary reference preferred
// - frequency code 00 8 kHz, 01 1.544 MHz, 10 2.048 MHz, 11 backplane
// - secondary code 11 uses the B 8 MHz clock, ignoring its source field
// - primary code 11 uses the A 8 MHz clock, ignoring its source field
// - active backplane A primary aligns output frames to the A frame signal
// - active backplane B secondary aligns output frames to the B frame
// - failure detect 00 automatic, 01 external except in primary master
// - inversion bit high inverts both backplane reference inputs
module dpllms_top (
  // system
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // dpll control, pclk domain
  input wire logic active_is_secondary,
  output logic a_group_drive_enable,
  output logic b_group_drive_enable,
  output logic preferred_ref_select,
  output logic [1:0] primary_freq_field,
  output logic [1:0] secondary_freq_field,
  output logic failure_detect_external,
  output logic interval_error_reset,
  // link domain inputs
  input wire logic link_clk,
  input wire logic backplane_ref_one,
  input wire logic backplane_ref_two,
  input wire logic [7:0] local_ref,
  input wire logic backplane_a_8mhz_clock,
  input wire logic backplane_b_8mhz_clock,
  input wire logic backplane_a_frame,
  input wire logic backplane_b_frame,
  // link domain outputs
  output logic primary_reference,
  output logic secondary_reference,
  output logic frame_align,
  output logic frame_align_valid
);
  typedef struct packed {
    logic [15:0] mode_one;
    logic [15:0] mode_two;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic a_drv;
    logic b_drv;
    logic pref;
    logic [1:0] pfreq;
    logic [1:0] sfreq;
    logic ext_fd;
    logic ierr;
  } dpllms_bus_type;
  typedef struct packed {
    logic [dpllms_pkg::LNK_W-1:0] s1;
    logic [dpllms_pkg::LNK_W-1:0] s2;
    logic frame;
    logic frame_valid;
  } dpllms_link_type;
  dpllms_bus_type q, d;
  dpllms_link_type l_q, l_d;
  dpllms_pkg::dpllms_role_type role;
  logic [dpllms_pkg::CFG_W-1:0] cfg_word;
  logic [dpllms_pkg::CFG_W-1:0] cfg_l;
  logic cfg_busy;
  logic setup;
  logic hit;
  logic [31:0] rd_val;
  logic [15:0] status;
  logic [1:0] fdm;
  logic pri_bp;
  logic sec_bp;
  logic l_pri_bp;
  logic l_sec_bp;
  logic l_actsec;

  // ==========================================================
  // mode decode
  assign role = dpllms_pkg::dpllms_role_type'(
    {q.mode_one[dpllms_pkg::M1_BDRV], q.mode_one[dpllms_pkg::M1_ADRV]});
  assign fdm = q.mode_two[dpllms_pkg::M2_FDM_LO +: 2];
  assign pri_bp = q.mode_one[dpllms_pkg::M1_PFREQ_LO +: 2]
    == dpllms_pkg::FREQ_BPCLK;
  assign sec_bp = q.mode_one[dpllms_pkg::M1_SFREQ_LO +: 2]
    == dpllms_pkg::FREQ_BPCLK;
  always_comb begin
    status = '0;
    status[dpllms_pkg::ST_ROLE_LO +: 2] = role;
    status[dpllms_pkg::ST_EXTFD] = q.ext_fd;
    status[dpllms_pkg::ST_PRIBP] = pri_bp;
    status[dpllms_pkg::ST_SECBP] = sec_bp;
    status[dpllms_pkg::ST_BUSY] = cfg_busy;
  end

  // ==========================================================
  // apb decode
  assign setup = psel && !penable;
  always_comb begin
    hit = 1'b1;
    rd_val = '0;
    case (paddr)
      dpllms_pkg::ADDR_MODE_ONE: rd_val = {16'h0000, q.mode_one};
      dpllms_pkg::ADDR_MODE_TWO: rd_val = {16'h0000, q.mode_two};
      dpllms_pkg::ADDR_STATUS: begin
        rd_val = {16'h0000, status};
        hit = !pwrite;
      end
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // register file and control outputs
  always_comb begin
    d = q;
    if (ce) begin
      if (setup) begin
        d.ready = 1'b1;
        d.slverr = !hit;
        d.rdata = (hit && !pwrite) ? rd_val : 32'h0000_0000;
      end else if (psel && penable && q.ready) begin
        d.ready = 1'b0;
        d.slverr = 1'b0;
        if (pwrite && !q.slverr) begin
          if (paddr == dpllms_pkg::ADDR_MODE_ONE)
            d.mode_one = pwdata[15:0] & dpllms_pkg::MODE_ONE_MASK;
          if (paddr == dpllms_pkg::ADDR_MODE_TWO)
            d.mode_two = pwdata[15:0] & dpllms_pkg::MODE_TWO_MASK;
        end
      end
      case (role)
        dpllms_pkg::ROLE_PRIMARY: begin
          d.a_drv = 1'b1;
          d.b_drv = 1'b0;
        end
        dpllms_pkg::ROLE_SECONDARY: begin
          d.a_drv = 1'b0;
          d.b_drv = 1'b1;
        end
        default: begin
          // both bits set is treated as slave so no group is double driven
          d.a_drv = 1'b0;
          d.b_drv = 1'b0;
        end
      endcase
      d.pref = q.mode_one[dpllms_pkg::M1_PREF];
      d.pfreq = q.mode_one[dpllms_pkg::M1_PFREQ_LO +: 2];
      d.sfreq = q.mode_one[dpllms_pkg::M1_SFREQ_LO +: 2];
      d.ext_fd = (fdm == dpllms_pkg::FDM_EXT)
        && (role != dpllms_pkg::ROLE_PRIMARY);
      d.ierr = q.mode_two[dpllms_pkg::M2_IERR];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.mode_one <= dpllms_pkg::MODE_ONE_RESET;
      q.mode_two <= dpllms_pkg::MODE_TWO_RESET;
    end else begin
      q <= d;
    end
  end
  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign a_group_drive_enable = q.a_drv;
  assign b_group_drive_enable = q.b_drv;
  assign preferred_ref_select = q.pref;
  assign primary_freq_field = q.pfreq;
  assign secondary_freq_field = q.sfreq;
  assign failure_detect_external = q.ext_fd;
  assign interval_error_reset = q.ierr;

  // ==========================================================
  // configuration crossing into the link domain
  assign cfg_word = {active_is_secondary,
    q.mode_two[dpllms_pkg::M2_INV],
    q.mode_one[dpllms_pkg::M1_SFREQ_LO +: 2],
    q.mode_one[dpllms_pkg::M1_SSRC_LO +: 4],
    q.mode_one[dpllms_pkg::M1_PFREQ_LO +: 2],
    q.mode_one[dpllms_pkg::M1_PSRC_LO +: 4]};
  dpllms_cfg_sync #(
    .W(dpllms_pkg::CFG_W)
  ) u_cfg_sync (
    .src_clk(pclk),
    .rst_n(presetn),
    .src_ce(ce),
    .src_data(cfg_word),
    .busy(cfg_busy),
    .dst_clk(link_clk),
    .dst_data(cfg_l)
  );

  // ==========================================================
  // link domain: input synchronisers and frame alignment
  assign l_pri_bp = cfg_l[dpllms_pkg::CFG_PFREQ_LO +: 2]
    == dpllms_pkg::FREQ_BPCLK;
  assign l_sec_bp = cfg_l[dpllms_pkg::CFG_SFREQ_LO +: 2]
    == dpllms_pkg::FREQ_BPCLK;
  assign l_actsec = cfg_l[dpllms_pkg::CFG_ACTSEC];
  always_comb begin
    l_d = l_q;
    l_d.s1 = {backplane_b_frame, backplane_a_frame,
      backplane_b_8mhz_clock, backplane_a_8mhz_clock,
      local_ref, backplane_ref_two, backplane_ref_one};
    l_d.s2 = l_q.s1;
    if (l_actsec) begin
      l_d.frame_valid = l_sec_bp;
      l_d.frame = l_sec_bp && l_q.s2[dpllms_pkg::LNK_FRB];
    end else begin
      l_d.frame_valid = l_pri_bp;
      l_d.frame = l_pri_bp && l_q.s2[dpllms_pkg::LNK_FRA];
    end
  end
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) l_q <= '0;
    else l_q <= l_d;
  end
  assign frame_align = l_q.frame;
  assign frame_align_valid = l_q.frame_valid;

  // ==========================================================
  // reference selection
  dpllms_ref_mux u_pri_mux (
    .clk(link_clk),
    .rst_n(presetn),
    .sel(cfg_l[dpllms_pkg::CFG_PSRC_LO +: 4]),
    .use_bp_clk(l_pri_bp),
    .invert(cfg_l[dpllms_pkg::CFG_INV]),
    .bp_clock(l_q.s2[dpllms_pkg::LNK_ACLK]),
    .bp_one(l_q.s2[dpllms_pkg::LNK_BP1]),
    .bp_two(l_q.s2[dpllms_pkg::LNK_BP2]),
    .local_ref(l_q.s2[dpllms_pkg::LNK_LOCAL_LO +: 8]),
    .ref_out(primary_reference)
  );
  dpllms_ref_mux u_sec_mux (
    .clk(link_clk),
    .rst_n(presetn),
    .sel(cfg_l[dpllms_pkg::CFG_SSRC_LO +: 4]),
    .use_bp_clk(l_sec_bp),
    .invert(cfg_l[dpllms_pkg::CFG_INV]),
    .bp_clock(l_q.s2[dpllms_pkg::LNK_BCLK]),
    .bp_one(l_q.s2[dpllms_pkg::LNK_BP1]),
    .bp_two(l_q.s2[dpllms_pkg::LNK_BP2]),
    .local_ref(l_q.s2[dpllms_pkg::LNK_LOCAL_LO +: 8]),
    .ref_out(secondary_reference)
  );

  // ==========================================================
  // checks
  logic [15:0] wr_one_exp;
  logic [7:0] l_local;
  logic sec_local_exp;
  logic pri_bp1_exp;
  assign wr_one_exp = pwdata[15:0] & dpllms_pkg::MODE_ONE_MASK;
  assign l_local = l_q.s2[dpllms_pkg::LNK_LOCAL_LO +: 8];
  assign sec_local_exp = l_local[cfg_l[dpllms_pkg::CFG_SSRC_LO +: 3]];
  assign pri_bp1_exp = l_q.s2[dpllms_pkg::LNK_BP1]
    ^ cfg_l[dpllms_pkg::CFG_INV];

  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_wr_one;
    psel && penable && pwrite && pready && !pslverr && ce
      && paddr == dpllms_pkg::ADDR_MODE_ONE;
  endsequence

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup |=> pready)
    else $error("no ready after setup");
  a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (s_setup and !hit) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");
  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_one |=> q.mode_one == $past(wr_one_exp))
    else $error("mode one write lost");
  a_primary_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && role == dpllms_pkg::ROLE_PRIMARY
      |=> a_group_drive_enable && !b_group_drive_enable)
    else $error("primary master drive wrong");
  a_secondary_drive: assert property (@(posedge pclk)
    disable iff (!presetn)
    ce && role == dpllms_pkg::ROLE_SECONDARY
      |=> !a_group_drive_enable && b_group_drive_enable)
    else $error("secondary master drive wrong");
  a_slave_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && role == dpllms_pkg::ROLE_SLAVE
      |=> !a_group_drive_enable && !b_group_drive_enable)
    else $error("slave drives a group");
  a_pref_primary: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !q.mode_one[dpllms_pkg::M1_PREF] |=> !preferred_ref_select)
    else $error("preferred reference not primary");
  a_freq_copy: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> secondary_freq_field
      == $past(q.mode_one[dpllms_pkg::M1_SFREQ_LO +: 2])
      && primary_freq_field
      == $past(q.mode_one[dpllms_pkg::M1_PFREQ_LO +: 2]))
    else $error("frequency field mismatch");
  a_fdm_primary: assert property (@(posedge pclk) disable iff (!presetn)
    ce && role == dpllms_pkg::ROLE_PRIMARY
      |=> !failure_detect_external)
    else $error("external detect in primary master");
  a_fdm_ext: assert property (@(posedge pclk) disable iff (!presetn)
    ce && fdm == dpllms_pkg::FDM_EXT && role == dpllms_pkg::ROLE_SLAVE
      |=> failure_detect_external)
    else $error("external detect not selected");
  a_ierr_reset: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> interval_error_reset
      == $past(q.mode_two[dpllms_pkg::M2_IERR]))
    else $error("interval error reset mismatch");
  a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(q))
    else $error("state moved while clock enable low");
  a_sec_bpclk: assert property (@(posedge link_clk) disable iff (!presetn)
    l_sec_bp |=> secondary_reference
      == $past(l_q.s2[dpllms_pkg::LNK_BCLK]))
    else $error("secondary not on B clock");
  a_pri_bpclk: assert property (@(posedge link_clk) disable iff (!presetn)
    l_pri_bp |=> primary_reference
      == $past(l_q.s2[dpllms_pkg::LNK_ACLK]))
    else $error("primary not on A clock");
  a_frame_a: assert property (@(posedge link_clk) disable iff (!presetn)
    !l_actsec && l_pri_bp |=> frame_align_valid
      && frame_align == $past(l_q.s2[dpllms_pkg::LNK_FRA]))
    else $error("frame not aligned to A");
  a_frame_b: assert property (@(posedge link_clk) disable iff (!presetn)
    l_actsec && l_sec_bp |=> frame_align_valid
      && frame_align == $past(l_q.s2[dpllms_pkg::LNK_FRB]))
    else $error("frame not aligned to B");
  a_local_src: assert property (@(posedge link_clk) disable iff (!presetn)
    !l_sec_bp && cfg_l[dpllms_pkg::CFG_SSRC_LO + 3]
      |=> secondary_reference == $past(sec_local_exp))
    else $error("local source selection wrong");
  a_bp_invert: assert property (@(posedge link_clk) disable iff (!presetn)
    !l_pri_bp && cfg_l[dpllms_pkg::CFG_PSRC_LO +: 4] == dpllms_pkg::SRC_BP_ONE
      |=> primary_reference == $past(pri_bp1_exp))
    else $error("backplane inversion wrong");
endmodule // dpllms_top

/* dpllms_ref_source.sv */
// model of the backplane and local reference sources at the link pins
`timescale 1ns/1ns
module dpllms_ref_source (
  // link clock and requested levels
  input wire logic link_clk,
  input wire logic [13:0] pattern,
  // reference pins
  output logic backplane_ref_one,
  output logic backplane_ref_two,
  output logic [7:0] local_ref,
  output logic backplane_a_8mhz_clock,
  output logic backplane_b_8mhz_clock,
  output logic backplane_a_frame,
  output logic backplane_b_frame
);
  // ==========================================================
  // sources change only at link clock edges, unrelated to pclk
  initial begin
    {backplane_b_frame, backplane_a_frame, backplane_b_8mhz_clock,
     backplane_a_8mhz_clock, local_ref, backplane_ref_two,
     backplane_ref_one} = 14'h0;
  end
  always @(posedge link_clk) begin
    {backplane_b_frame, backplane_a_frame, backplane_b_8mhz_clock,
     backplane_a_8mhz_clock, local_ref, backplane_ref_two,
     backplane_ref_one} <= pattern;
  end
endmodule // dpllms_ref_source

/* dpllms_top_tb.sv */
// self-checking bench for the reference mode select block
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  num_errors++; $display("unexpected at %0t: got %h expected %h", \
  $time, got, exp); end end
module dpllms_top_tb;
  // ==========================================================
  // signals
  logic pclk = 0, link_clk = 0, presetn = 0, ce = 1;
  logic psel = 0, penable = 0, pwrite = 0, active_is_secondary = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, a_group_drive_enable, b_group_drive_enable;
  logic preferred_ref_select, failure_detect_external, interval_error_reset;
  logic [1:0] primary_freq_field, secondary_freq_field;
  logic backplane_ref_one, backplane_ref_two, backplane_a_8mhz_clock;
  logic backplane_b_8mhz_clock, backplane_a_frame, backplane_b_frame;
  logic primary_reference, secondary_reference, frame_align;
  logic frame_align_valid;
  logic [7:0] local_ref;
  logic [13:0] pattern = 14'h0;
  logic [31:0] seed = 32'he401;
  int num_errors = 0, checks = 0;
  always #50 pclk = ~pclk;
  always #3 link_clk = ~link_clk;
  dpllms_top dpllms_top_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .active_is_secondary,
    .a_group_drive_enable, .b_group_drive_enable, .preferred_ref_select,
    .primary_freq_field, .secondary_freq_field, .failure_detect_external,
    .interval_error_reset, .link_clk, .backplane_ref_one,
    .backplane_ref_two, .local_ref, .backplane_a_8mhz_clock,
    .backplane_b_8mhz_clock, .backplane_a_frame, .backplane_b_frame,
    .primary_reference, .secondary_reference, .frame_align,
    .frame_align_valid);
  dpllms_ref_source dpllms_ref_source_i (.link_clk, .pattern,
    .backplane_ref_one, .backplane_ref_two, .local_ref,
    .backplane_a_8mhz_clock, .backplane_b_8mhz_clock, .backplane_a_frame,
    .backplane_b_frame);
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic exp_ref(logic [3:0] s, logic bp, logic bpclk,
                                   logic inv);
    if (bp) return bpclk;
    if (s == 4'h0) return pattern[0] ^ inv;
    if (s == 4'h1) return pattern[1] ^ inv;
    if (s[3]) return pattern[2 + s[2:0]];
    return 1'b0;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) num_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle();
    int n;
    n = 0;
    repeat (3) @(posedge pclk);
    do begin
      apb(1'b0, dpllms_pkg::ADDR_STATUS, 32'h0, rd, err);
      n++;
    end while (rd[dpllms_pkg::ST_BUSY] !== 1'b0 && n < 20);
    if (rd[dpllms_pkg::ST_BUSY] !== 1'b0) num_errors++;
    repeat (2) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin : watchdog
    #1_000_000;
    num_errors++;
    print_verdict();
  end
  initial begin : main
    logic [15:0] m1, m2;
    logic [1:0] pf, sf;
    logic v, e1, e2;
    int r, f, i;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, rd, err);
      `CHK(rd, 32'h0)
    end
    `CHK({a_group_drive_enable, b_group_drive_enable}, 2'b00)
    for (r = 0; r < 4; r++) begin
      m1 = 16'(xs());
      m1[14:13] = 2'(r);
      apb(1'b1, dpllms_pkg::ADDR_MODE_ONE, {16'h0, m1}, rd, err);
      for (f = 0; f < 4; f++) begin
        m2 = 16'(xs());
        m2[9:8] = 2'(f);
        apb(1'b1, dpllms_pkg::ADDR_MODE_TWO, {16'h0, m2}, rd, err);
        settle();
        apb(1'b0, dpllms_pkg::ADDR_MODE_ONE, 32'h0, rd, err);
        `CHK(rd, {16'h0, m1 & dpllms_pkg::MODE_ONE_MASK})
        apb(1'b0, dpllms_pkg::ADDR_MODE_TWO, 32'h0, rd, err);
        `CHK(rd, {16'h0, m2 & dpllms_pkg::MODE_TWO_MASK})
        `CHK(a_group_drive_enable, r == 1)
        `CHK(b_group_drive_enable, r == 2)
        `CHK(failure_detect_external, f == 1 && r != 1)
        `CHK(interval_error_reset, m2[10])
        `CHK(preferred_ref_select, m1[12])
        `CHK({secondary_freq_field, primary_freq_field}, m1[11:8])
      end
    end
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b1, dpllms_pkg::ADDR_STATUS, 32'hffff, rd, err);
    `CHK(err, 1'b1)
    for (i = 0; i < 32; i++) begin
      pf = i[4] ? 2'h3 : 2'(xs() % 3);
      sf = i[4] ? 2'(xs() % 3) : 2'h3;
      m1 = {4'h0, sf, pf, ~i[3:0], i[3:0]};
      pattern <= 14'(xs());
      v = seed[7];
      active_is_secondary <= seed[20];
      apb(1'b1, dpllms_pkg::ADDR_MODE_ONE, {16'h0, m1}, rd, err);
      apb(1'b1, dpllms_pkg::ADDR_MODE_TWO, {26'h0, v, 5'h0}, rd, err);
      settle();
      e1 = exp_ref(i[3:0], pf == 3, pattern[10], v);
      e2 = exp_ref(~i[3:0], sf == 3, pattern[11], v);
      `CHK(primary_reference, e1)
      `CHK(secondary_reference, e2)
      `CHK(frame_align_valid, active_is_secondary ? sf == 3 : pf == 3)
      if (frame_align_valid === 1'b1) begin
        `CHK(frame_align, pattern[12 + active_is_secondary])
      end
    end
    // clock enable low: a change of active reference must not cross
    v = active_is_secondary;
    ce <= 1'b0;
    active_is_secondary <= !v;
    repeat (6) @(posedge pclk);
    `CHK(frame_align_valid, !v)
    ce <= 1'b1;
    settle();
    `CHK(frame_align_valid, v)
    print_verdict();
  end
endmodule // dpllms_top_tb
